//--- hw/sra_params.svh
// Constants for the set-all-ones execution block
`ifndef SRA_PARAMS_SVH
`define SRA_PARAMS_SVH
`define SRA_OPC_MASK 16'hFE00
`define SRA_OPC_VAL 16'h6800
`define SRA_ABIT_POS 8
`define SRA_ALL_ONES 8'hFF
`define SRA_DATA_IDLE 8'h00
`define SRA_IDX_LIMIT 8'h5F
`define SRA_ACC_SPLIT 8'h60
`define SRA_ACC_LO_BANK 4'h0
`define SRA_ACC_HI_BANK 4'hF
`define SRA_ADDR_RST 12'h000
`define SRA_CLK_HZ 20000000
`define SRA_Q_PER_CYCLE 4
`endif

//--- hw/sra_pkg.sv
// Types for the set-all-ones execution block
package sra_pkg;
   typedef enum logic [1:0] {
      SRA_Q1 = 2'b00,
      SRA_Q2 = 2'b01,
      SRA_Q3 = 2'b10,
      SRA_Q4 = 2'b11
   } sra_qph_t;

   typedef enum logic [1:0] {
      SRA_MODE_ACCESS = 2'b00,
      SRA_MODE_BANKED = 2'b01,
      SRA_MODE_INDEXED = 2'b10
   } sra_mode_t;

   typedef struct packed {
      logic re;
      logic we;
      logic [11:0] addr;
      logic [7:0] data;
   } sra_mem_req_t;
endpackage : sra_pkg

//--- hw/sra_set_all_ones_exec.sv
// Execution of the set-all-ones register instruction with bank and indexed addressing
//
// Functional notes
// - Write FFh to the addressed register
// - Access bit 0: shared access bank, ignore bank_select_reg
// - Access bit 1: bank_select_reg plus operand address
// - Extended set, access 0, operand <=5Fh: indexed
`timescale 1ns/1ns
`default_nettype none
`include "sra_params.svh"

module sra_set_all_ones_exec #(
   parameter int ADDR_W = 12
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic ext_set_en,
   input wire logic [3:0] bank_select_reg,
   input wire logic [ADDR_W-1:0] index_base,
   output logic cycle_q1,
   output logic instr_taken,
   output logic busy,
   output logic flags_hold,
   output sra_pkg::sra_mem_req_t mem_req
);

   ////////////////////////////////////////////////////////////////////////////
   // Address formation; the mode function is shared by logic and checks

   function automatic logic [ADDR_W-1:0] sra_addr_of(
      input logic [7:0] f,
      input logic abit,
      input logic ext,
      input logic [3:0] bank_sel,
      input logic [ADDR_W-1:0] base
   );
      logic [ADDR_W-1:0] a;
      a = '0;
      if (!abit && ext && (f <= `SRA_IDX_LIMIT)) begin
         // Offset from the index base; carry out of the top is dropped on purpose
         a = ADDR_W'(base + {{(ADDR_W-8){1'b0}}, f});
      end else if (!abit) begin
         // Access bank below 60h is bank 0, from 60h up the top bank
         a = (f < `SRA_ACC_SPLIT) ? ADDR_W'({`SRA_ACC_LO_BANK, f})
                                  : ADDR_W'({`SRA_ACC_HI_BANK, f});
      end else begin
         a = ADDR_W'({bank_sel, f});
      end
      return a;
   endfunction : sra_addr_of

   function automatic sra_pkg::sra_mode_t sra_mode_of(
      input logic [7:0] f,
      input logic abit,
      input logic ext
   );
      sra_pkg::sra_mode_t m;
      m = sra_pkg::SRA_MODE_BANKED;
      if (!abit && ext && (f <= `SRA_IDX_LIMIT)) begin
         m = sra_pkg::SRA_MODE_INDEXED;
      end else if (!abit) begin
         m = sra_pkg::SRA_MODE_ACCESS;
      end
      return m;
   endfunction : sra_mode_of

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   wire logic [7:0] opnd_f;
   wire logic acc_bit;
   wire logic opc_hit;
   wire logic [ADDR_W-1:0] tgt_addr;
   wire sra_pkg::sra_mode_t tgt_mode;
   wire logic take;

   assign opnd_f = instr_word[7:0];
   assign acc_bit = instr_word[`SRA_ABIT_POS];
   assign opc_hit = (instr_word & `SRA_OPC_MASK) == `SRA_OPC_VAL;
   assign tgt_addr = sra_addr_of(opnd_f, acc_bit, ext_set_en, bank_select_reg, index_base);
   assign tgt_mode = sra_mode_of(opnd_f, acc_bit, ext_set_en);

   ////////////////////////////////////////////////////////////////////////////
   // Instruction cycle phases and execution

   sra_pkg::sra_qph_t qph_r;
   sra_pkg::sra_qph_t qph_nxt;
   logic busy_r;
   logic busy_nxt;
   sra_pkg::sra_mode_t mode_r;
   sra_pkg::sra_mem_req_t req_r;
   sra_pkg::sra_mem_req_t req_nxt;

   // New words are only taken at Q1, so one instruction spans exactly Q1..Q4
   assign take = instr_valid && opc_hit && (qph_r == sra_pkg::SRA_Q1);

   always_comb begin
      unique case (qph_r)
         sra_pkg::SRA_Q1: qph_nxt = sra_pkg::SRA_Q2;
         sra_pkg::SRA_Q2: qph_nxt = sra_pkg::SRA_Q3;
         sra_pkg::SRA_Q3: qph_nxt = sra_pkg::SRA_Q4;
         sra_pkg::SRA_Q4: qph_nxt = sra_pkg::SRA_Q1;
      endcase
   end

   assign busy_nxt = take ? 1'b1 : ((qph_r == sra_pkg::SRA_Q4) ? 1'b0 : busy_r);

   always_comb begin
      req_nxt = req_r;
      req_nxt.re = take;
      // Write lands in Q4; previous contents play no part
      req_nxt.we = busy_r && (qph_r == sra_pkg::SRA_Q3);
      req_nxt.data = (busy_r && (qph_r == sra_pkg::SRA_Q3)) ? `SRA_ALL_ONES
                                                            : `SRA_DATA_IDLE;
      if (take) begin
         req_nxt.addr = tgt_addr;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         qph_r <= sra_pkg::SRA_Q1;
         busy_r <= 1'b0;
         mode_r <= sra_pkg::SRA_MODE_BANKED;
         req_r <= '{re: 1'b0, we: 1'b0, addr: `SRA_ADDR_RST, data: `SRA_DATA_IDLE};
      end else begin
         qph_r <= qph_nxt;
         busy_r <= busy_nxt;
         mode_r <= take ? tgt_mode : mode_r;
         req_r <= req_nxt;
      end
   end

   assign cycle_q1 = (qph_r == sra_pkg::SRA_Q1);
   assign instr_taken = take;
   assign busy = busy_r;
   // Status flags are frozen from Q2 through Q4 of the instruction cycle
   assign flags_hold = busy_r;
   assign mem_req = req_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_take_mode(logic abit_c, logic idx_c);
      take && (acc_bit == abit_c) && ((tgt_mode == sra_pkg::SRA_MODE_INDEXED) == idx_c);
   endsequence

   sequence s_exec_flow;
      mem_req.re && busy ##2 mem_req.we && busy ##1 !busy && !mem_req.we;
   endsequence

   a_write_all_ones: assert property (@(posedge clk_sys) disable iff (!nrst)
      mem_req.we |-> (mem_req.data == `SRA_ALL_ONES))
      else $error("write data is not all ones");

   a_access_bank_addr: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_take_mode(1'b0, 1'b0) |=> (mem_req.addr[7:0] == $past(opnd_f)) &&
      (mem_req.addr[ADDR_W-1:8] == (($past(opnd_f) < `SRA_ACC_SPLIT) ?
         `SRA_ACC_LO_BANK : `SRA_ACC_HI_BANK)))
      else $error("access bank address wrong");

   a_banked_addr: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_take_mode(1'b1, 1'b0) |=>
      (mem_req.addr == {$past(bank_select_reg), $past(opnd_f)}))
      else $error("banked address wrong");

   a_indexed_addr: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_take_mode(1'b0, 1'b1) |=> (mode_r == sra_pkg::SRA_MODE_INDEXED) &&
      (mem_req.addr == ADDR_W'($past(index_base) + {{(ADDR_W-8){1'b0}}, $past(opnd_f)})))
      else $error("indexed address wrong");

   a_indexed_when: assert property (@(posedge clk_sys) disable iff (!nrst)
      take && (tgt_mode == sra_pkg::SRA_MODE_INDEXED) |->
      !acc_bit && ext_set_en && (opnd_f <= `SRA_IDX_LIMIT))
      else $error("indexed mode taken without its conditions");

   a_single_cycle: assert property (@(posedge clk_sys) disable iff (!nrst)
      take |=> s_exec_flow)
      else $error("instruction did not finish in one cycle");

   a_flags_frozen: assert property (@(posedge clk_sys) disable iff (!nrst)
      take |=> flags_hold [*3] ##1 !flags_hold)
      else $error("flags not held during execution");

   a_no_stray_op: assert property (@(posedge clk_sys) disable iff (!nrst)
      mem_req.we |-> $past(take, 3) && ($past(instr_word[15:9], 3) == `SRA_OPC_VAL >> 9))
      else $error("write without a matching opcode");

endmodule : sra_set_all_ones_exec

`default_nettype wire

//--- sim/sra_mem_model.sv
// Behavioural banked data memory seen by the set-all-ones block
`timescale 1ns/1ns
`default_nettype none
module sra_mem_model (
   input wire logic clk_sys,
   input wire sra_pkg::sra_mem_req_t mem_req
);
   logic [7:0] mem [0:4095];
   // Prefilled so that a missing write stays visible
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'h5A;
      end
   end
   always @(posedge clk_sys) begin
      if (mem_req.we) begin
         mem[mem_req.addr] <= mem_req.data;
      end
   end
endmodule : sra_mem_model
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the set-all-ones execution block
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk_sys;
   logic nrst;
   logic instr_valid;
   logic [15:0] instr_word;
   logic ext_set_en;
   logic [3:0] bank_select_reg;
   logic [11:0] index_base;
   logic cycle_q1;
   logic instr_taken;
   logic busy;
   logic flags_hold;
   sra_pkg::sra_mem_req_t mem_req;
   int err_total;
   int num_checks;
   sra_set_all_ones_exec #(.ADDR_W(12)) i_sra_set_all_ones_exec (.clk_sys(clk_sys),
      .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
      .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg), .index_base(index_base),
      .cycle_q1(cycle_q1), .instr_taken(instr_taken), .busy(busy), .flags_hold(flags_hold),
      .mem_req(mem_req));
   sra_mem_model i_sra_mem_model (.clk_sys(clk_sys), .mem_req(mem_req));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict
   task automatic wait_q1();
      for (int n = 0; cycle_q1 !== 1'b1; n++) begin
         if (n > 8) begin
            chk("q1_wait", 16'h0001, 16'h0000);
            print_verdict();
         end
         @(negedge clk_sys);
      end
   endtask : wait_q1
   // One whole instruction cycle; ends on the next Q1 so ops run back to back
   task automatic run_op(input logic [15:0] w, input logic ext, input logic [3:0] bank_sel,
                         input logic [11:0] exp_a);
      wait_q1();
      instr_word = w;
      ext_set_en = ext;
      bank_select_reg = bank_sel;
      instr_valid = 1'b1;
      #1 chk("instr_taken", 16'h0001, {15'h0, instr_taken});
      @(negedge clk_sys);
      instr_valid = 1'b0;
      chk("re", 16'h0001, {15'h0, mem_req.re});
      chk("addr", {4'h0, exp_a}, {4'h0, mem_req.addr});
      chk("flags_hold", 16'h0001, {15'h0, flags_hold});
      chk("busy", 16'h0001, {15'h0, busy});
      repeat (2) @(negedge clk_sys);
      chk("we", 16'h0001, {15'h0, mem_req.we});
      chk("data", 16'h00FF, {8'h00, mem_req.data});
      chk("re_end", 16'h0000, {15'h0, mem_req.re});
      chk("busy_q4", 16'h0001, {15'h0, busy});
      @(negedge clk_sys);
      chk("mem", 16'h00FF, {8'h00, i_sra_mem_model.mem[exp_a]});
      chk("we_end", 16'h0000, {15'h0, mem_req.we});
      chk("data_end", 16'h0000, {8'h00, mem_req.data});
      chk("busy_end", 16'h0000, {15'h0, busy});
      chk("flags_end", 16'h0000, {15'h0, flags_hold});
   endtask : run_op
   task automatic t_banked();
      run_op(16'h6934, 1'b0, 4'h5, 12'h534);
      run_op(16'h69FF, 1'b1, 4'hF, 12'hFFF);
      run_op(16'h6905, 1'b1, 4'h3, 12'h305);
   endtask : t_banked
   task automatic t_access();
      run_op(16'h6810, 1'b0, 4'hA, 12'h010);
      run_op(16'h685F, 1'b0, 4'hA, 12'h05F);
      run_op(16'h6860, 1'b0, 4'hA, 12'hF60);
   endtask : t_access
   task automatic t_indexed();
      run_op(16'h685F, 1'b1, 4'h7, 12'h04F);
      run_op(16'h6800, 1'b1, 4'h7, 12'hFF0);
      run_op(16'h6861, 1'b1, 4'h7, 12'hF61);
      // Second base, no wrap
      index_base = 12'h200;
      run_op(16'h6810, 1'b1, 4'h7, 12'h210);
   endtask : t_indexed
   // Wrong opcode in Q1, then a good word outside Q1: both ignored
   task automatic t_refused();
      wait_q1();
      instr_word = 16'h6A12;
      instr_valid = 1'b1;
      #1 chk("taken_bad", 16'h0000, {15'h0, instr_taken});
      @(negedge clk_sys);
      chk("re_bad", 16'h0000, {15'h0, mem_req.re});
      instr_word = 16'h6812;
      #1 chk("taken_q2", 16'h0000, {15'h0, instr_taken});
      @(negedge clk_sys);
      instr_valid = 1'b0;
      chk("re_q2", 16'h0000, {15'h0, mem_req.re});
   endtask : t_refused
   // Reset in mid-instruction: the pending write must be dropped
   task automatic t_reset();
      wait_q1();
      instr_word = 16'h6930;
      bank_select_reg = 4'h3;
      instr_valid = 1'b1;
      @(negedge clk_sys);
      instr_valid = 1'b0;
      nrst = 1'b0;
      @(negedge clk_sys);
      chk("rst_busy", 16'h0000, {15'h0, busy});
      chk("rst_req", 16'h0000, {2'b00, mem_req.re, mem_req.we, mem_req.addr});
      chk("rst_q1", 16'h0001, {15'h0, cycle_q1});
      nrst = 1'b1;
      run_op(16'h6920, 1'b1, 4'h2, 12'h220);
      chk("aborted", 16'h005A, {8'h00, i_sra_mem_model.mem[12'h330]});
   endtask : t_reset
   initial begin
      err_total = 0;
      num_checks = 0;
      nrst = 1'b0;
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      ext_set_en = 1'b0;
      bank_select_reg = 4'h0;
      // Base near the top so the indexed sum wraps
      index_base = 12'hFF0;
      repeat (20) @(negedge clk_sys);
      nrst = 1'b1;
      t_banked();
      t_access();
      t_indexed();
      t_refused();
      t_reset();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
